/* File: tcnv_pkg.sv */
package tcnv_pkg;
  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int WORD_BITS = 11;
  localparam int CHK_POS = 0;
  localparam int FINE_LSB = 1;
  localparam int MID_LSB = 6;
  localparam int COARSE_LSB = 9;
  localparam logic [10:0] ERASE_CODE = 11'h001;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int HALF_BIT_NS = 4200;
  localparam int HALF_BIT_CYC = (HALF_BIT_NS * 1000) / CLK_PERIOD_PS;
  localparam int PRE_PULSE_NS = 4000;
  localparam int PRE_PULSE_CYC = (PRE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_MIN_MS = 40;
  localparam int PULSE_MAX_MS = 80;
  localparam int PULSE_TGT_MS = 60;
  localparam int PULSE_CYC_DEF = (PULSE_TGT_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int SETTLE_CYC = 64;
  // ---------------------------------------------------------------
  // operations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {OP_LOAD, OP_PROG_ALL, OP_PROG_BIT, OP_READ} tcnv_op_t;
endpackage

/* File: tcnv_host.sv */
`timescale 1ns/1ps
module tcnv_host
  import tcnv_pkg::*;
#(
  parameter int PULSE_CYC = PULSE_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire tcnv_op_t cmdOp,
  input wire logic [1:0] cmdCoarse,
  input wire logic [2:0] cmdMiddle,
  input wire logic [4:0] cmdFine,
  input wire logic [3:0] cmdBitSel,
  output logic doneValid,
  output logic [3:0] doneBit,
  output logic doneReadBit,
  output logic linkClk,
  output logic serialDataIn,
  output logic programVoltagePin,
  input wire logic pvSenseIn,
  output logic holdShift
);
  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_WAIT, ST_PULSE, ST_SETTLE, ST_END} tcnv_state_t;
  tcnv_state_t state_r;
  tcnv_op_t op_r;
  logic [10:0] word_r;
  logic [3:0] bitCnt_r;
  logic [3:0] sel_r;
  logic [31:0] timer_r;
  logic senseMeta_r;
  logic senseSync_r;
  logic doneValid_r;
  logic doneRead_r;
  logic [3:0] doneBit_r;
  logic linkClk_r;
  logic data_r;
  logic pv_r;
  logic holdShift_r;

  // ---------------------------------------------------------------
  // word building
  // ---------------------------------------------------------------
  function automatic logic [10:0] oneZeroAt(input logic [3:0] pos);
    logic [10:0] w;
    w = '1;
    w[pos] = 1'b0;
    return w;
  endfunction

  function automatic logic [10:0] buildWord(input tcnv_op_t op, input logic [1:0] c, input logic [2:0] m,
                                            input logic [4:0] f, input logic [3:0] pos);
    logic [10:0] code;
    code = {c, m, f, 1'b1};
    case (op)
      OP_LOAD: buildWord = code;
      OP_PROG_ALL: buildWord = ~code;
      OP_PROG_BIT: buildWord = oneZeroAt(pos);
      OP_READ: buildWord = oneZeroAt(pos);
      default: buildWord = code;
    endcase
  endfunction

  assign cmdReady = (state_r == ST_IDLE);
  wire logic cmdBitOk = (cmdBitSel < 4'(WORD_BITS));
  wire logic cmdTake = cmdValid && cmdReady && (cmdBitOk || cmdOp == OP_LOAD || cmdOp == OP_PROG_ALL);

  // ---------------------------------------------------------------
  // pin sense synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      senseMeta_r <= 1'b0;
      senseSync_r <= 1'b0;
    end else begin
      senseMeta_r <= pvSenseIn;
      senseSync_r <= senseMeta_r;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      op_r <= OP_LOAD;
      word_r <= '0;
      bitCnt_r <= '0;
      sel_r <= '0;
      timer_r <= '0;
      linkClk_r <= 1'b0;
      data_r <= 1'b0;
      pv_r <= 1'b0;
      holdShift_r <= 1'b0;
      doneValid_r <= 1'b0;
      doneRead_r <= 1'b0;
      doneBit_r <= '0;
    end else begin
      doneValid_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (cmdTake) begin
            op_r <= cmdOp;
            sel_r <= cmdBitSel;
            word_r <= buildWord(cmdOp, cmdCoarse, cmdMiddle, cmdFine, cmdBitSel);
            bitCnt_r <= '0;
            timer_r <= 32'(HALF_BIT_CYC - 1);
            linkClk_r <= 1'b0;
            // a held clock from an earlier load is released here, so the hold flag goes too
            holdShift_r <= 1'b0;
            state_r <= ST_LOW;
          end
        end
        ST_LOW: begin
          // data set up while clock is low, so it changes after the falling edge
          if (timer_r == '0) begin
            linkClk_r <= 1'b1;
            timer_r <= 32'(HALF_BIT_CYC - 1);
            state_r <= ST_HIGH;
          end else begin
            data_r <= word_r[0];
            timer_r <= timer_r - 32'd1;
          end
        end
        ST_HIGH: begin
          if (bitCnt_r == 4'(WORD_BITS - 1)) begin
            // no twelfth edge: clock stays high after the last bit
            holdShift_r <= 1'b1;
            timer_r <= (op_r == OP_READ) ? 32'(SETTLE_CYC - 1) : 32'(PRE_PULSE_CYC - 1);
            state_r <= (op_r == OP_LOAD) ? ST_END : ((op_r == OP_READ) ? ST_SETTLE : ST_WAIT);
          end else if (timer_r == '0) begin
            linkClk_r <= 1'b0;
            word_r <= {1'b0, word_r[10:1]};
            bitCnt_r <= bitCnt_r + 4'd1;
            timer_r <= 32'(HALF_BIT_CYC - 1);
            state_r <= ST_LOW;
          end else begin
            timer_r <= timer_r - 32'd1;
          end
        end
        ST_WAIT: begin
          if (timer_r == '0) begin
            pv_r <= 1'b1;
            timer_r <= 32'(PULSE_CYC - 1);
            state_r <= ST_PULSE;
          end else begin
            timer_r <= timer_r - 32'd1;
          end
        end
        ST_PULSE: begin
          if (timer_r == '0) begin
            pv_r <= 1'b0;
            state_r <= ST_END;
          end else begin
            timer_r <= timer_r - 32'd1;
          end
        end
        ST_SETTLE: begin
          // pull-up plus synchroniser need time before the level is trusted
          if (timer_r == '0) begin
            doneRead_r <= (sel_r == 4'(CHK_POS)) ? 1'b1 : senseSync_r;
            state_r <= ST_END;
          end else begin
            timer_r <= timer_r - 32'd1;
          end
        end
        ST_END: begin
          // a load keeps the clock high so the shifted code stays in force
          if (op_r != OP_LOAD) begin
            linkClk_r <= 1'b0;
            holdShift_r <= 1'b0;
          end
          doneValid_r <= 1'b1;
          doneBit_r <= sel_r;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign linkClk = linkClk_r;
  assign serialDataIn = data_r;
  assign programVoltagePin = pv_r;
  assign holdShift = holdShift_r;
  assign doneValid = doneValid_r;
  assign doneBit = doneBit_r;
  assign doneReadBit = doneRead_r;

  // ---------------------------------------------------------------
  // guard counters
  // ---------------------------------------------------------------
  // counted apart from the sequencer so the checks do not mirror its own counters
  logic linkClkPrev_r;
  logic [3:0] riseCnt_r;
  logic [31:0] pulseCnt_r;
  logic [31:0] gapCnt_r;
  wire logic linkRise = linkClk_r && !linkClkPrev_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      linkClkPrev_r <= 1'b0;
    end else begin
      linkClkPrev_r <= linkClk_r;
    end
  end

  // rising clock edges since the command was taken
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      riseCnt_r <= '0;
    end else if (cmdTake) begin
      riseCnt_r <= '0;
    end else if (linkRise) begin
      riseCnt_r <= riseCnt_r + 4'd1;
    end
  end

  // cycles the programming pulse has stood
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulseCnt_r <= '0;
    end else if (pv_r) begin
      pulseCnt_r <= pulseCnt_r + 32'd1;
    end else begin
      pulseCnt_r <= '0;
    end
  end

  // cycles since the last clock rise; conservative by one cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gapCnt_r <= '0;
    end else if (linkRise) begin
      gapCnt_r <= '0;
    end else begin
      gapCnt_r <= gapCnt_r + 32'd1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  pulse_clk_high_a: assert property (@(posedge sys_clk) disable iff (rst) pv_r |-> linkClk_r)
    else $error("program pulse without clock high");
  pulse_start_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(pv_r) |-> $past(state_r) == ST_WAIT)
    else $error("program pulse not after wait");
  no_extra_edge_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(linkClk_r) |-> bitCnt_r < 4'(WORD_BITS))
    else $error("too many clock edges");
  data_stable_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    linkClk_r && $past(linkClk_r) |-> $stable(data_r))
    else $error("data changed with clock high");
  pulse_low_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == ST_IDLE |-> !pv_r)
    else $error("pulse left on");
  edge_count_a: assert property (@(posedge sys_clk) disable iff (rst)
    riseCnt_r <= 4'(WORD_BITS))
    else $error("more than eleven clock rises");
  edge_total_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == ST_END |-> riseCnt_r == 4'(WORD_BITS))
    else $error("transfer ended without eleven rises");
  pulse_width_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(pv_r) |-> pulseCnt_r == 32'(PULSE_CYC))
    else $error("program pulse width wrong");
  pre_gap_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(pv_r) |-> gapCnt_r >= 32'(PRE_PULSE_CYC))
    else $error("program pulse too soon after last rise");
  hold_clk_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    holdShift_r |-> linkClk_r)
    else $error("hold flag with clock low");
endmodule

/* File: tcnv_trim_dev.sv */
`timescale 1ns/1ps
module tcnv_trim_dev (
  input wire logic linkClk,
  input wire logic serialDataIn,
  input wire logic programVoltagePin,
  output logic pvSenseIn,
  output logic [10:0] shiftReg,
  output logic [10:0] nvMem,
  output logic [9:0] capCode,
  output int edgeCount,
  output realtime pulseLen,
  output realtime preGap
);
  realtime lastRise;
  realtime pvRise;
  initial begin
    shiftReg = 11'h000;
    nvMem = 11'h000;
    edgeCount = 0;
    lastRise = 0.0;
    pvRise = 0.0;
  end
  always @(posedge linkClk) begin
    shiftReg <= {serialDataIn, shiftReg[10:1]};
    edgeCount <= edgeCount + 1;
    lastRise = $realtime;
  end
  // fuse mode only sets bits, all-bits mode can clear
  always @(posedge programVoltagePin) begin
    pvRise = $realtime;
    preGap = pvRise - lastRise;
    if (!shiftReg[0]) begin
      nvMem <= ~shiftReg;
    end else begin
      nvMem <= nvMem | ~shiftReg;
    end
  end
  always @(negedge programVoltagePin) pulseLen = $realtime - pvRise;
  assign capCode = linkClk ? shiftReg[10:1] : nvMem[10:1];
  // pin pulled up unless the program pin is low, clock is high and the word is not a valid single-bit query, or such a query reads a zero
  always_comb begin
    if (programVoltagePin || !linkClk) begin
      pvSenseIn = 1'b1;
    end else if ($countones(~shiftReg) != 1) begin
      pvSenseIn = 1'b0;
    end else if (!shiftReg[0]) begin
      pvSenseIn = 1'b1;
    end else begin
      pvSenseIn = |(nvMem & ~shiftReg);
    end
  end
endmodule

/* File: tcnv_host_tb_top.sv */
`timescale 1ns/1ps
module tcnv_host_tb_top;
  import tcnv_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic sys_clk, rst, cmdValid, cmdReady, doneValid, doneReadBit, linkClk, serialDataIn;
  logic programVoltagePin, pvSenseIn, holdShift;
  tcnv_op_t cmdOp;
  logic [1:0] cmdCoarse;
  logic [2:0] cmdMiddle;
  logic [4:0] cmdFine;
  logic [3:0] cmdBitSel, doneBit;
  logic [10:0] shiftReg, nvMem;
  logic [9:0] capCode;
  int edgeCount, failCount, checks, cycles;
  realtime pulseLen, preGap;
  // short pulse keeps the run small
  tcnv_host #(.PULSE_CYC(50)) tcnv_host_inst (.sys_clk(sys_clk), .rst(rst), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdCoarse(cmdCoarse), .cmdMiddle(cmdMiddle), .cmdFine(cmdFine),
    .cmdBitSel(cmdBitSel), .doneValid(doneValid), .doneBit(doneBit), .doneReadBit(doneReadBit),
    .linkClk(linkClk), .serialDataIn(serialDataIn), .programVoltagePin(programVoltagePin),
    .pvSenseIn(pvSenseIn), .holdShift(holdShift));
  tcnv_trim_dev tcnv_trim_dev_inst (.linkClk(linkClk), .serialDataIn(serialDataIn),
    .programVoltagePin(programVoltagePin), .pvSenseIn(pvSenseIn), .shiftReg(shiftReg), .nvMem(nvMem),
    .capCode(capCode), .edgeCount(edgeCount), .pulseLen(pulseLen), .preGap(preGap));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run_op(input tcnv_op_t op, input logic [9:0] code, input logic [3:0] sel);
    @(negedge sys_clk);
    cmdOp = op;
    {cmdCoarse, cmdMiddle, cmdFine} = code;
    cmdBitSel = sel;
    cmdValid = 1'b1;
    @(negedge sys_clk);
    cmdValid = 1'b0;
    while (doneValid !== 1'b1) @(negedge sys_clk);
  endtask
  task automatic report_and_stop();
    if (failCount == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_refuse();
    @(negedge sys_clk);
    cmdOp = OP_READ;
    cmdBitSel = 4'hB;
    cmdValid = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk("ready", 11'h001, 11'(cmdReady));
    chk("edges", 11'h000, 11'(edgeCount));
    cmdValid = 1'b0;
  endtask
  task automatic t_load();
    run_op(OP_LOAD, 10'h177, 4'h0);
    chk("shift", 11'h2EF, shiftReg);
    chk("edges", 11'h00B, 11'(edgeCount));
    chk("hold", 11'h001, 11'(holdShift & linkClk));
  endtask
  task automatic t_prog();
    run_op(OP_PROG_ALL, 10'h042, 4'h0);
    chk("mem", 11'h085, nvMem);
    chk("pulse", 11'h0C8, 11'(int'(pulseLen)));
    chk("gap", 11'h001, 11'(preGap >= 4000.0));
    chk("cap", 11'h042, 11'(capCode));
  endtask
  task automatic t_read();
    run_op(OP_READ, 10'h000, 4'h6);
    chk("query", 11'h7BF, shiftReg);
    chk("bit", 11'h006, 11'(doneBit));
    chk("read", 11'h000, 11'(doneReadBit));
  endtask
  // ---------------------------------------------------------------
  // run
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      failCount++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdOp = OP_LOAD;
    {cmdCoarse, cmdMiddle, cmdFine, cmdBitSel} = 14'h0000;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    t_refuse();
    t_load();
    t_prog();
    t_read();
    report_and_stop();
  end
endmodule
